// ==== src/pmt_map.svh ====
// Purpose: constants for the MII nibble-side timing core
// Assumes: clk runs at 40 MHz, 25 ns per cycle
// Notes: cycle counts are derived from the printed times below
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH

`define PMT_ATLEAST1(x) (((x) < 1) ? 1 : (x))

// clock and nibble clocks
`define PMT_CLK_NS      25
`define PMT_NIB100_NS   40
`define PMT_NIB10_NS    400
`define PMT_HALF100     `PMT_ATLEAST1(`PMT_NIB100_NS / 2 / `PMT_CLK_NS)
`define PMT_HALF10      `PMT_ATLEAST1(`PMT_NIB10_NS / 2 / `PMT_CLK_NS)

// bit times and latency limits, longest times rounded down
`define PMT_BIT10_NS    100
`define PMT_BIT100_NS   10
`define PMT_RXLAT10_BT  7
`define PMT_TXLAT10_BT  2
`define PMT_JLAT_BT     3
`define PMT_CRS100_BT   4
`define PMT_CRSON10_BT  2
`define PMT_CRSOFF10_BT 4
`define PMT_RXLAT10_CYC \
  `PMT_ATLEAST1(`PMT_RXLAT10_BT * `PMT_BIT10_NS / `PMT_CLK_NS)
`define PMT_TXLAT10_CYC \
  `PMT_ATLEAST1(`PMT_TXLAT10_BT * `PMT_BIT10_NS / `PMT_CLK_NS)
`define PMT_JLAT_CYC \
  `PMT_ATLEAST1(`PMT_JLAT_BT * `PMT_BIT100_NS / `PMT_CLK_NS)
`define PMT_CRS100_CYC \
  `PMT_ATLEAST1(`PMT_CRS100_BT * `PMT_BIT100_NS / `PMT_CLK_NS)

// management clock limits and data valid time
`define PMT_MDC_MIN_NS   400
`define PMT_MDC_PHASE_NS 160
`define PMT_MDIO_VAL_NS  300
`define PMT_MDIO_VAL_CYC \
  `PMT_ATLEAST1(`PMT_MDIO_VAL_NS / `PMT_CLK_NS)

// management frame layout
`define PMT_MDIO_PRE    6'h20
`define PMT_MDIO_HEAD   5'h0C
`define PMT_MDIO_LAST   5'h11
`define PMT_MDIO_OP_RD  2'h2

// start-of-stream marker nibble placed on the line at 100 Mb/s
`define PMT_J_NIB       4'hC

`endif

// ==== src/pmt_mdio.sv ====
// Purpose: management serial slave answering read frames
// Assumes: mdc and mdio come from the station, unsynchronised
// Notes: any register address reads the status word
`timescale 1ns/100ps
`include "pmt_map.svh"

module pmt_mdio #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // management pins
  input  wire logic        mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioOe,
  // word returned on reads
  input  wire logic [15:0] statusWord
);

  logic                 mdcS1, mdcS2, mdcS3;
  logic                 mdiS1, mdiS2;
  pmt_pkg::pmt_mdio_e   state;
  logic [5:0]           preCnt;
  logic [4:0]           cnt;
  logic [11:0]          hdr;
  logic                 rd;
  logic [15:0]          shift;

  // edge detect and frame decode
  wire        mdcEdge = mdcS2 & ~mdcS3;
  wire [12:0] newHdr  = {hdr, mdiS2};
  wire        hdrRd   = newHdr[12] & (newHdr[11:10] == `PMT_MDIO_OP_RD)
                        & (newHdr[9:5] == PHY_ADDR);
  wire        preDone = (preCnt == `PMT_MDIO_PRE);

  // synchronisers for the station pins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {mdcS3, mdcS2, mdcS1} <= 3'h0;
      {mdiS2, mdiS1}        <= 2'h0;
    end else begin
      {mdcS3, mdcS2, mdcS1} <= {mdcS2, mdcS1, mdc};
      {mdiS2, mdiS1}        <= {mdiS1, mdioIn};
    end
  end

  // frame walker, output moves only on a sampled mdc rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state   <= pmt_pkg::MD_IDLE;
      preCnt  <= 6'h00;
      cnt     <= 5'h00;
      hdr     <= 12'h000;
      rd      <= 1'b0;
      shift   <= 16'h0000;
      mdioOut <= 1'b0;
      mdioOe  <= 1'b0;
    end else if (mdcEdge) begin
      unique case (state)
        pmt_pkg::MD_IDLE: begin
          if (mdiS2) begin
            preCnt <= preDone ? preCnt : preCnt + 6'h01;
          end else begin
            preCnt <= 6'h00;
            cnt    <= 5'h00;
            if (preDone) begin
              state <= pmt_pkg::MD_HEAD;
            end
          end
        end
        pmt_pkg::MD_HEAD: begin
          hdr <= newHdr[11:0];
          cnt <= cnt + 5'h01;
          if (cnt == `PMT_MDIO_HEAD) begin
            rd    <= hdrRd;
            shift <= statusWord;
            cnt   <= 5'h00;
            state <= pmt_pkg::MD_DATA;
          end
        end
        pmt_pkg::MD_DATA: begin
          cnt <= cnt + 5'h01;
          if (cnt == `PMT_MDIO_LAST) begin
            mdioOe <= 1'b0;
            state  <= pmt_pkg::MD_IDLE;
          end else begin
            mdioOe  <= rd;
            mdioOut <= (cnt == 5'h00) ? 1'b0 : shift[15];
            if (cnt != 5'h00) begin
              shift <= {shift[14:0], 1'b0};
            end
          end
        end
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // read frames are driven from the edge after the header
  property p_mdio_drive;
    (mdcEdge && state == pmt_pkg::MD_DATA && rd && cnt != `PMT_MDIO_LAST)
      |=> mdioOe;
  endproperty
  a_mdio_drive: assert property (p_mdio_drive)
    else $error("mdio not driven during read data");

  // the line is released after the last data bit
  property p_mdio_release;
    (mdcEdge && state == pmt_pkg::MD_DATA && cnt == `PMT_MDIO_LAST)
      |=> !mdioOe ##1 !mdioOe;
  endproperty
  a_mdio_release: assert property (p_mdio_release)
    else $error("mdio not released after frame");

  // a change on mdio always follows a sampled mdc rise by one cycle
  property p_mdio_moves;
    $changed(mdioOut) |-> $past(mdcEdge);
  endproperty
  a_mdio_moves: assert property (p_mdio_moves)
    else $error("mdio changed away from an mdc rise");

endmodule : pmt_mdio

// ==== src/pmt_phy_mii.sv ====
// Purpose: nibble-side MII timing core of a 10/100 line device
// Assumes: one 40 MHz clock; all pins are asynchronous to it
// Notes: at 100 Mb/s the nibble clock is limited to two clk cycles
`timescale 1ns/100ps
`include "pmt_map.svh"

module pmt_phy_mii #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // mode straps
  input  wire logic       speed100,
  input  wire logic       fullDuplex,
  // transmit side toward the controller
  output logic            txClk,
  input  wire logic [3:0] txd,
  input  wire logic       txEn,
  input  wire logic       txEr,
  // receive side toward the controller
  output logic            rxClk,
  output logic      [3:0] rxd,
  output logic            rxDv,
  output logic            rxEr,
  output logic            crs,
  // line transmit pair, one nibble per nibble clock
  output logic      [3:0] lineTransmitPair,
  output logic            lineTxEnable,
  output logic            lineTxError,
  // line receive pair, one nibble per nibble clock
  input  wire logic [3:0] lineReceivePair,
  input  wire logic       lineRxActive,
  input  wire logic       lineRxError,
  // management pins
  input  wire logic       mdc,
  input  wire logic       mdioIn,
  output logic            mdioOut,
  output logic            mdioOe
);

  localparam logic [3:0] HALF100 = 4'(`PMT_HALF100);
  localparam logic [3:0] HALF10  = 4'(`PMT_HALF10);

  logic       spdS1, spdS2, dupS1, dupS2;
  logic [3:0] txdS1, txdS2;
  logic       txEnS1, txEnS2, txErS1, txErS2;
  logic [3:0] lrxS1, lrxS2;
  logic       lrxActS1, lrxActS2, lrxErrS1, lrxErrS2;
  logic [3:0] halfCnt;
  logic [1:0] riseDly;
  logic       txEnPrev;

  // nibble clock divider, shared by both MII clocks
  wire [3:0] halfLen  = spdS2 ? HALF100 : HALF10;
  wire       halfTick = (halfCnt >= halfLen - 4'h1);
  wire       riseEv   = halfTick & ~txClk;
  wire       fallEv   = halfTick & txClk;
  wire       capEv    = riseDly[1];

  // transmit decode at the capture point
  wire       jStart   = spdS2 & txEnS2 & ~txEnPrev;
  wire [3:0] next_tx  = jStart ? `PMT_J_NIB : (txEnS2 ? txdS2 : 4'h0);
  wire       txNow    = capEv ? txEnS2 : txEnPrev;
  wire       next_crs = lrxActS2 | (~dupS2 & txNow);
  wire [15:0] statusWord = {13'h0000, spdS2, dupS2, crs};

  // two-flop synchronisers for every pin input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {spdS2, spdS1, dupS2, dupS1}        <= 4'h0;
      {txdS2, txdS1}                      <= 8'h00;
      {txEnS2, txEnS1, txErS2, txErS1}    <= 4'h0;
      {lrxS2, lrxS1}                      <= 8'h00;
      {lrxActS2, lrxActS1}                <= 2'h0;
      {lrxErrS2, lrxErrS1}                <= 2'h0;
    end else begin
      {spdS2, spdS1, dupS2, dupS1} <= {spdS1, speed100, dupS1, fullDuplex};
      {txdS2, txdS1}               <= {txdS1, txd};
      {txEnS2, txEnS1}             <= {txEnS1, txEn};
      {txErS2, txErS1}             <= {txErS1, txEr};
      {lrxS2, lrxS1}               <= {lrxS1, lineReceivePair};
      {lrxActS2, lrxActS1}         <= {lrxActS1, lineRxActive};
      {lrxErrS2, lrxErrS1}         <= {lrxErrS1, lineRxError};
    end
  end

  // clock generation; both MII clocks toggle together
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halfCnt <= 4'h0;
      txClk   <= 1'b0;
      rxClk   <= 1'b0;
      riseDly <= 2'h0;
    end else begin
      halfCnt <= halfTick ? 4'h0 : halfCnt + 4'h1;
      txClk   <= txClk ^ halfTick;
      rxClk   <= txClk ^ halfTick;
      riseDly <= {riseDly[0], riseEv};  // rise seen through the sync delay
    end
  end

  // transmit capture and line output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txEnPrev         <= 1'b0;
      lineTransmitPair <= 4'h0;
      lineTxEnable     <= 1'b0;
      lineTxError      <= 1'b0;
    end else if (capEv) begin
      txEnPrev         <= txEnS2;
      lineTransmitPair <= next_tx;
      lineTxEnable     <= txEnS2;
      lineTxError      <= txEnS2 & txErS2;
    end
  end

  // carrier sense follows line activity and, in half duplex, txEn
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crs <= 1'b0;
    end else begin
      crs <= next_crs;
    end
  end

  // receive outputs change on the falling rxClk edge only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxd  <= 4'h0;
      rxDv <= 1'b0;
      rxEr <= 1'b0;
    end else if (fallEv) begin
      rxd  <= lrxActS2 ? lrxS2 : 4'h0;
      rxDv <= lrxActS2;
      rxEr <= lrxActS2 & lrxErrS2;
    end
  end

  // management slave
  pmt_mdio #(
    .PHY_ADDR   (PHY_ADDR)
  ) u_mdio (
    .clk        (clk),
    .rst        (rst),
    .mdc        (mdc),
    .mdioIn     (mdioIn),
    .mdioOut    (mdioOut),
    .mdioOe     (mdioOe),
    .statusWord (statusWord)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_txRise;
    $rose(txClk);
  endsequence

  sequence s_high10;
    txClk [*8] ##1 !txClk;
  endsequence

  sequence s_capTxOn;
    capEv && txEnS2;
  endsequence

  // 10 Mb/s: 8 cycles high, 400 ns per nibble clock
  property p_rate10;
    (s_txRise and !spdS2) |-> s_high10;
  endproperty
  a_rate10: assert property (p_rate10)
    else $error("txClk high phase wrong at 10 Mb/s");

  // 100 Mb/s: one cycle per phase, the fastest clk allows
  property p_rate100;
    ($rose(rxClk) && spdS2) |=> !rxClk ##1 rxClk;
  endproperty
  a_rate100: assert property (p_rate100)
    else $error("rxClk phase wrong at 100 Mb/s");

  // every rising txClk leads to a capture one cycle later
  property p_capture;
    s_txRise |=> capEv;
  endproperty
  a_capture: assert property (p_capture)
    else $error("transmit inputs not captured after txClk rise");

  // captured data reaches the line on the next cycle
  property p_txLatency;
    s_capTxOn |=> lineTxEnable && lineTransmitPair == $past(next_tx);
  endproperty
  a_txLatency: assert property (p_txLatency)
    else $error("line output late after capture");

  // start marker replaces the first nibble at 100 Mb/s
  property p_jStart;
    (s_capTxOn and !txEnPrev and spdS2) |=> lineTransmitPair == `PMT_J_NIB;
  endproperty
  a_jStart: assert property (p_jStart)
    else $error("start marker missing at 100 Mb/s");

  // carrier rises with a captured txEn in half duplex
  property p_crsOn;
    (s_capTxOn and !dupS2) |=> crs;
  endproperty
  a_crsOn: assert property (p_crsOn)
    else $error("crs did not follow txEn");

  // carrier falls with txEn when the line is quiet
  property p_crsOff;
    (capEv && !txEnS2 && !lrxActS2) |=> !crs;
  endproperty
  a_crsOff: assert property (p_crsOff)
    else $error("crs held after txEn dropped");

  // receive outputs do not move at a rising rxClk
  property p_rxStable;
    $rose(rxClk) |-> $stable(rxd) && $stable(rxDv) && $stable(rxEr);
  endproperty
  a_rxStable: assert property (p_rxStable)
    else $error("receive outputs moved at rxClk rise");

  // line activity reaches rxDv within 7 bit times less the sync delay
  property p_rxLatency;
    ($rose(lrxActS2) && !spdS2) |-> ##[1:26] rxDv;
  endproperty
  a_rxLatency: assert property (p_rxLatency)
    else $error("receive latency exceeded at 10 Mb/s");

endmodule : pmt_phy_mii

// ==== src/pmt_pkg.sv ====
// Purpose: types shared by the MII timing core
// Assumes: nothing beyond the map header
// Notes: one-hot codes written out
package pmt_pkg;

  // management frame walker states
  typedef enum logic [2:0] {
    MD_IDLE = 3'h1,
    MD_HEAD = 3'h2,
    MD_DATA = 3'h4
  } pmt_mdio_e;

endpackage : pmt_pkg

// ==== test/pmt_mac_model.sv ====
// Purpose: controller and management station model facing the MII core
// Assumes: its pins change at the fall of clk, except stOe and stOut at the start of md_read
// Notes: the mdio pull-up is resolved in the bench
`timescale 1ns/100ps
`include "pmt_map.svh"

module pmt_mac_model (
  // clock and mode
  input  wire logic       clk,
  input  wire logic       txClk,
  input  wire logic       speed100,
  // transmit pins
  output logic      [3:0] txd,
  output logic            txEn,
  output logic            txEr,
  // management pins
  output logic            mdc,
  output logic            stOut,
  output logic            stOe,
  input  wire logic       mdioWire
);
  logic [4:0] expQ [$];  // expected {error, nibble} on the line

  // idle pins at time zero
  initial begin
    {txd, txEn, txEr} = 6'h00;
    {mdc, stOut, stOe} = 3'h0;
  end

  // n nibbles then one idle slot carrying a stray error flag
  task automatic send_frame(input int n, input int errAt);
    for (int i = 0; i <= n; i++) begin
      @(negedge txClk);
      @(negedge clk);  // settled half a clk cycle or more before the next rise
      txd = 4'($urandom);
      txEn = (i < n);
      txEr = (i == errAt) || (i == n);
      if (i < n)
        expQ.push_back({txEr, (i == 0 && speed100) ? `PMT_J_NIB : txd});
    end
  endtask : send_frame

  // one station bit: 250 ns low, 250 ns high, period 500 ns
  task automatic md_bit(input logic b);
    stOut = b;
    mdc = 1'b0;
    repeat (10) @(negedge clk);
    mdc = 1'b1;
    repeat (10) @(negedge clk);
  endtask : md_bit

  // header out, then turnaround and data sampled 300 ns after each rise
  task automatic md_read(input logic [1:0] op, input logic [4:0] phy,
                         input logic [4:0] regAddr, output logic [16:0] got);
    logic [45:0] head;
    head = {32'hFFFFFFFF, 2'h1, op, phy, regAddr};
    stOe = 1'b1;
    for (int i = 45; i >= 0; i--)
      md_bit(head[i]);
    stOe = 1'b0;
    for (int i = 16; i >= 0; i--) begin
      mdc = 1'b0;
      repeat (10) @(negedge clk);
      mdc = 1'b1;
      repeat (12) @(negedge clk);
      got[i] = mdioWire;
    end
    // one more rise lets the device release the line
    mdc = 1'b0;
    repeat (10) @(negedge clk);
    mdc = 1'b1;
    repeat (10) @(negedge clk);
    mdc = 1'b0;
  endtask : md_read
endmodule : pmt_mac_model

// ==== test/pmt_phy_mii_tb.sv ====
// Purpose: self-checking bench of the MII timing core
// Assumes: 40 MHz clk; all four strap settings run in turn
// Notes: line side and straps driven here, the rest by the model
`timescale 1ns/100ps
`include "pmt_map.svh"
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin \
  nErrors++; $display("ERROR %0t: got %0h want %0h", $time, a, b); end end

module pmt_phy_mii_tb;
  localparam longint PER100 = 2 * `PMT_HALF100 * `PMT_CLK_NS;
  localparam longint PER10  = 2 * `PMT_HALF10 * `PMT_CLK_NS;
  localparam longint RXLIM  = `PMT_RXLAT10_BT * `PMT_BIT10_NS;
  logic        clk, rst, speed100, fullDuplex, txClk, rxClk, txEn, txEr;
  logic        rxDv, rxEr, crs, lineTxEnable, lineTxError, lineRxActive;
  logic        lineRxError, mdc, mdioOut, mdioOe, stOut, stOe, rxSeen;
  logic [3:0]  txd, rxd, lineTransmitPair, lineReceivePair, rxdPrev;
  logic [4:0]  rxQ [$];
  logic [4:0]  exp;
  logic [16:0] got;
  wire  logic  mdioWire;
  longint      tRise, tPrev, tLine, lat;
  int          nErrors, samplesChecked, cycles;

  // tri-state management line with pull-up
  assign mdioWire = mdioOe ? mdioOut : (stOe ? stOut : 1'b1);

  pmt_phy_mii #(.PHY_ADDR(5'h01)) uut (
    .clk(clk), .rst(rst), .speed100(speed100), .fullDuplex(fullDuplex),
    .txClk(txClk), .txd(txd), .txEn(txEn), .txEr(txEr),
    .rxClk(rxClk), .rxd(rxd), .rxDv(rxDv), .rxEr(rxEr), .crs(crs),
    .lineTransmitPair(lineTransmitPair), .lineTxEnable(lineTxEnable),
    .lineTxError(lineTxError), .lineReceivePair(lineReceivePair),
    .lineRxActive(lineRxActive), .lineRxError(lineRxError),
    .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mdioOut), .mdioOe(mdioOe));

  pmt_mac_model mac (
    .clk(clk), .txClk(txClk), .speed100(speed100), .txd(txd),
    .txEn(txEn), .txEr(txEr), .mdc(mdc), .stOut(stOut), .stOe(stOe),
    .mdioWire(mdioWire));

  always #12.5 clk = ~clk;

  // counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      nErrors++;
      $display("ERROR %0t: timeout", $time);
      print_verdict();
    end
  end

  // new straps under a 6 cycle reset, then let the clocks settle
  task automatic reset_to(input logic sp, input logic fd);
    @(negedge clk);
    {speed100, fullDuplex, rst} = {sp, fd, 1'b1};
    tRise = 0;  // no period check across a reset
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (12) @(negedge clk);
  endtask : reset_to

  // n line nibbles, one per receive clock, then idle with error raised
  task automatic line_frame(input int n, input int errAt);
    for (int i = 0; i <= n; i++) begin
      @(negedge rxClk);
      @(negedge clk);
      lineReceivePair = 4'($urandom);
      lineRxActive = (i < n);
      lineRxError = (i == errAt) || (i == n);
      if (i < n)
        rxQ.push_back({lineRxError, lineReceivePair});
    end
  endtask : line_frame

  // nibble clock periods and common phase
  always @(posedge txClk) begin
    if (tRise != 0)
      `CHK($time - tRise, speed100 ? PER100 : PER10)
    tPrev = tRise;
    tRise = $time;
  end
  always @(negedge clk) `CHK(rxClk, txClk)

  // one line nibble per transmit clock, idle line all zero
  always @(negedge txClk) begin
    @(negedge clk);
    if (lineTxEnable === 1'b1) begin
      `CHK(mac.expQ.size() > 0, 1'b1)
      exp = mac.expQ.pop_front();
      `CHK({lineTxError, lineTransmitPair}, exp)
    end else
      `CHK({lineTxError, lineTransmitPair}, 5'h00)
  end

  // line start latency and carrier follow transmit enable
  // at 100 Mb/s the line moves on the next txClk rise, so use the one before
  always @(posedge lineTxEnable) begin
    @(negedge clk);
    lat = ($time - (speed100 ? tPrev : tRise)) / `PMT_CLK_NS;
    `CHK(lat, longint'(2))
    `CHK(crs, !fullDuplex)
  end
  always @(negedge lineTxEnable) begin
    @(negedge clk);
    `CHK(crs, 1'b0)
  end

  // rxd stable across each rxClk rise and receive outputs in order
  always @(negedge clk) begin
    if (rxClk === 1'b1 && !rxSeen) begin
      `CHK(rxd, rxdPrev)
      if (rxDv === 1'b1) begin
        exp = rxQ.pop_front();
        `CHK({rxEr, rxd}, exp)
      end else
        `CHK({rxEr, rxd}, 5'h00)
    end
    rxSeen = rxClk;
    rxdPrev = rxd;
  end

  // line to rxd latency at 10 Mb/s
  always @(posedge lineRxActive) tLine = $time;
  always @(posedge rxDv)
    if (!speed100)
      `CHK(($time - tLine) <= RXLIM, 1'b1)

  // main sequence over all strap settings
  initial begin
    {clk, rst, speed100, fullDuplex} = 4'h4;
    {lineReceivePair, lineRxActive, lineRxError} = 6'h00;
    nErrors = 0;
    samplesChecked = 0;
    cycles = 0;
    {tRise, tLine, rxSeen, rxdPrev} = '0;
    void'($urandom(32'h287E));
    for (int m = 0; m < 4; m++) begin
      reset_to(m[1], m[0]);
      mac.send_frame(1, -1);
      mac.send_frame(2 + $urandom % 8, 1);
      repeat (4) @(negedge txClk);
      line_frame(2 + $urandom % 8, 1);
      repeat (4) @(negedge rxClk);
      mac.md_read(`PMT_MDIO_OP_RD, 5'h01, 5'($urandom), got);
      `CHK(got, {14'h0, m[1], m[0], 1'b0})
      mac.md_read(m[0] ? 2'h1 : `PMT_MDIO_OP_RD,
                  m[0] ? 5'h01 : 5'h1E, 5'($urandom), got);
      `CHK(got, 17'h1FFFF)
    end
    `CHK(mac.expQ.size() + rxQ.size(), 0)
    print_verdict();
  end
endmodule : pmt_phy_mii_tb
